// ===== hdl/rmd_core.sv
// register map access and diagnostic alert logic
// assumes an APB master on pclk; scan and diagnostic events are one-cycle pulses
`timescale 1ns/1ps
// Behaviour
// - end-of-scan ADC check only for scan codes 0 or 1 with diag enable set
// - scale checks use bipolar conversion of plus and minus supply
// - full-scale result below FFF sets full-scale alert in safety status two
// - zero-scale result above 000 sets zero-scale alert in safety status two
// - protocol errors flag alert bits in general status one and two
// - protocol-error transactions are rejected before any address decode
// - user registers decode only in 0x00 to 0x98; holes act reserved
// - 0x2C-0x2F, 0x46 and 0x99-0xFF are reserved
// - clean access to reserved address raises no error
// - reserved writes are dropped, reserved reads give zero
// - checks cover all sixteen data bits including unused ones
// - unused bits are not stored and read as zero
// - spare config fields store and read back but steer nothing
// - broken balance switch gives exactly one balance switch alert
// - broken switch n gives high-threshold violation only on cell n
// - broken sense wire k gives low-threshold violations on adjacent cells
// - write to busy register is ignored and sets rejected alert
module rmd_core
	import rmd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic proto_err,
	input wire logic scan_done,
	input wire logic [2:0] adc_mode,
	input wire logic [11:0] fs_code,
	input wire logic [11:0] zs_code,
	input wire logic diag_done,
	input wire logic [NCELL-1:0] cell_over_hi,
	input wire logic [NCELL-1:0] cell_under_lo,
	input wire logic busy,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	output logic diag_run,
	output logic [2:0] diag_adc_mode
);
	// ----------------------------------------
	// decode
	// ----------------------------------------
	function automatic logic is_reserved(input logic [7:0] idx);
		is_reserved = (idx > USER_LAST) || (idx >= HOLE_LO && idx <= HOLE_HI)
			|| (idx == HOLE_ONE);
	endfunction

	function automatic logic is_status(input logic [7:0] idx);
		is_status = (idx == IDX_GENERAL_STATUS_ONE) || (idx == IDX_GENERAL_STATUS_TWO) || (idx == IDX_SAFETY2)
			|| (idx == IDX_DIAGRES) || (idx == IDX_BALALRT);
	endfunction

	logic [7:0] idx;
	logic access;
	logic clean;
	logic wr_ok;
	logic [15:0] wdata;
	logic [15:0] devcfg1;
	logic [15:0] devcfg2;
	logic [15:0] scanctl;
	logic [15:0] diag_select_one;
	logic [15:0] diag_select_two;
	logic [15:0] general_status_one;
	logic [15:0] general_status_two;
	logic [15:0] safety2;
	logic [NCELL-1:0] bal_hi;
	logic [NCELL-1:0] bal_lo;
	logic bal_sw_alert;
	logic [15:0] next_rdata;
	logic run_check;
	logic fs_bad;
	logic zs_bad;
	logic [NCELL-1:0] hi_set;
	logic [NCELL-1:0] lo_set;
	logic wr_busy;
	logic bad_strobe;

	assign idx = paddr[9:2];
	assign access = psel && penable && pready && clk_en;
	assign wdata = pwdata[15:0];
	// partial strobes on the low half count as a protocol fault
	assign bad_strobe = pwrite && (pstrb[1:0] != 2'b11);
	assign clean = !proto_err && !bad_strobe && (paddr[1:0] == 2'b00);
	// registers held by a running internal operation
	assign wr_busy = busy && (idx == IDX_SCANCTL || idx == IDX_DIAG_SELECT_ONE || idx == IDX_DIAG_SELECT_TWO);
	assign wr_ok = access && pwrite && clean && !is_reserved(idx) && !wr_busy;

	// ----------------------------------------
	// apb handshake
	// ----------------------------------------
	// one wait state: pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else if (clk_en) begin
			pready <= psel && penable && !pready;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else if (clk_en) begin
			// misaligned, faulty or badly strobed transfers are refused
			pslverr <= psel && penable && !pready
				&& (proto_err || bad_strobe || paddr[1:0] != 2'b00);
		end
	end

	// ----------------------------------------
	// writable registers
	// ----------------------------------------
	// spare config bits are kept for readback only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			devcfg1 <= ZERO16;
		end else if (wr_ok && idx == IDX_DEVCFG1) begin
			devcfg1 <= wdata & (DEVCFG1_MASK | DEVCFG1_SPARE);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			devcfg2 <= ZERO16;
		end else if (wr_ok && idx == IDX_DEVCFG2) begin
			devcfg2 <= wdata & (DEVCFG2_MASK | DEVCFG2_SPARE);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scanctl <= ZERO16;
		end else if (wr_ok && idx == IDX_SCANCTL) begin
			scanctl <= wdata & SCANCTL_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			diag_select_one <= ZERO16;
		end else if (wr_ok && idx == IDX_DIAG_SELECT_ONE) begin
			diag_select_one <= wdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			diag_select_two <= ZERO16;
		end else if (wr_ok && idx == IDX_DIAG_SELECT_TWO) begin
			diag_select_two <= wdata;
		end
	end

	// ----------------------------------------
	// end-of-scan adc check
	// ----------------------------------------
	assign run_check = scan_done && scanctl[SCAN_DIAG_EN_BIT]
		&& (scanctl[SCAN_CFG_LSB +: 3] == SCAN_ADC_A
		|| scanctl[SCAN_CFG_LSB +: 3] == SCAN_ADC_B);
	assign fs_bad = run_check && (fs_code < ADC_FULL);
	assign zs_bad = run_check && (zs_code > ADC_ZERO);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			diag_run <= 1'b0;
			diag_adc_mode <= 3'h0;
		end else if (clk_en) begin
			diag_run <= run_check;
			diag_adc_mode <= devcfg1[2:0];
		end
	end

	// ----------------------------------------
	// status registers, write one to clear, set wins
	// ----------------------------------------
	logic ev_proto;
	logic ev_reject;
	logic fs_alert;
	logic zs_alert;
	logic proto_alert1;
	logic reject_alert;
	logic proto_alert2;
	assign ev_proto = access && !clean;
	assign ev_reject = access && pwrite && clean && !is_reserved(idx) && wr_busy;

	// a clear that meets a new event leaves the bit set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fs_alert <= 1'b0;
		end else if (clk_en) begin
			if (wr_ok && idx == IDX_SAFETY2 && wdata[FS_ALERT_BIT]) begin
				fs_alert <= fs_bad;
			end else begin
				fs_alert <= fs_alert | fs_bad;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zs_alert <= 1'b0;
		end else if (clk_en) begin
			if (wr_ok && idx == IDX_SAFETY2 && wdata[ZS_ALERT_BIT]) begin
				zs_alert <= zs_bad;
			end else begin
				zs_alert <= zs_alert | zs_bad;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			proto_alert1 <= 1'b0;
		end else if (clk_en) begin
			if (wr_ok && idx == IDX_GENERAL_STATUS_ONE && wdata[S1_PROTO_BIT]) begin
				proto_alert1 <= ev_proto;
			end else begin
				proto_alert1 <= proto_alert1 | ev_proto;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reject_alert <= 1'b0;
		end else if (clk_en) begin
			if (wr_ok && idx == IDX_GENERAL_STATUS_ONE && wdata[S1_REJECT_BIT]) begin
				reject_alert <= ev_reject;
			end else begin
				reject_alert <= reject_alert | ev_reject;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			proto_alert2 <= 1'b0;
		end else if (clk_en) begin
			if (wr_ok && idx == IDX_GENERAL_STATUS_TWO && wdata[S2_PROTO_BIT]) begin
				proto_alert2 <= ev_proto;
			end else begin
				proto_alert2 <= proto_alert2 | ev_proto;
			end
		end
	end

	// unused status bits read as zero
	always_comb begin
		general_status_one = ZERO16;
		general_status_one[S1_PROTO_BIT] = proto_alert1;
		general_status_one[S1_REJECT_BIT] = reject_alert;
		general_status_two = ZERO16;
		general_status_two[S2_PROTO_BIT] = proto_alert2;
		safety2 = ZERO16;
		safety2[FS_ALERT_BIT] = fs_alert;
		safety2[ZS_ALERT_BIT] = zs_alert;
	end

	// ----------------------------------------
	// open-wire threshold results
	// ----------------------------------------
	genvar c;
	generate
		for (c = 0; c < NCELL; c++) begin : g_cell
			assign hi_set[c] = diag_done && cell_over_hi[c];
			assign lo_set[c] = diag_done && cell_under_lo[c];
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					bal_hi[c] <= 1'b0;
					bal_lo[c] <= 1'b0;
				end else if (clk_en) begin
					if (wr_ok && idx == IDX_BALHI) begin
						bal_hi[c] <= (bal_hi[c] & ~wdata[c]) | hi_set[c];
					end else begin
						bal_hi[c] <= bal_hi[c] | hi_set[c];
					end
					if (wr_ok && idx == IDX_BALLO) begin
						bal_lo[c] <= (bal_lo[c] & ~wdata[c]) | lo_set[c];
					end else begin
						bal_lo[c] <= bal_lo[c] | lo_set[c];
					end
				end
			end
		end
	endgenerate

	// single switch alert: exactly one high-threshold cell and no low ones
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bal_sw_alert <= 1'b0;
		end else if (clk_en) begin
			if (diag_done && $onehot(cell_over_hi) && cell_under_lo == '0) begin
				bal_sw_alert <= 1'b1;
			end else if (wr_ok && idx == IDX_BALALRT && wdata[0]) begin
				bal_sw_alert <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always_comb begin
		next_rdata = ZERO16;
		if (!is_reserved(idx)) begin
			unique case (idx)
				IDX_GENERAL_STATUS_ONE: next_rdata = general_status_one;
				IDX_GENERAL_STATUS_TWO: next_rdata = general_status_two;
				IDX_DEVCFG1: next_rdata = devcfg1;
				IDX_DEVCFG2: next_rdata = devcfg2;
				IDX_SCANCTL: next_rdata = scanctl;
				IDX_SAFETY2: next_rdata = safety2;
				IDX_BALALRT: next_rdata = {15'h0000, bal_sw_alert};
				IDX_BALHI: next_rdata = {2'h0, bal_hi};
				IDX_BALLO: next_rdata = {2'h0, bal_lo};
				IDX_DIAG_SELECT_ONE: next_rdata = diag_select_one;
				IDX_DIAG_SELECT_TWO: next_rdata = diag_select_two;
				default: next_rdata = ZERO16;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= ZERO32;
		end else if (clk_en) begin
			if (psel && penable && !pready && !pwrite && !proto_err) begin
				prdata <= {16'h0000, next_rdata};
			end else if (!psel) begin
				prdata <= ZERO32;
			end
		end
	end
endmodule // rmd_core

// ===== hdl/rmd_pkg.sv
// package of the register map access and diagnostic alert block
// assumes an APB master with 32-bit data; each register is one word at index*4
package rmd_pkg;
	// ----------------------------------------
	// address space
	// ----------------------------------------
	localparam logic [7:0] USER_LAST = 8'h98;
	localparam logic [7:0] HOLE_LO = 8'h2C;
	localparam logic [7:0] HOLE_HI = 8'h2F;
	localparam logic [7:0] HOLE_ONE = 8'h46;
	// register indices (address = index*4)
	localparam logic [7:0] IDX_GENERAL_STATUS_ONE = 8'h02;
	localparam logic [7:0] IDX_GENERAL_STATUS_TWO = 8'h03;
	localparam logic [7:0] IDX_DEVCFG1 = 8'h10;
	localparam logic [7:0] IDX_DEVCFG2 = 8'h11;
	localparam logic [7:0] IDX_SCANCTL = 8'h12;
	localparam logic [7:0] IDX_SAFETY2 = 8'h13;
	localparam logic [7:0] IDX_DIAGRES = 8'h14;
	localparam logic [7:0] IDX_BALALRT = 8'h15;
	localparam logic [7:0] IDX_BALHI = 8'h16;
	localparam logic [7:0] IDX_BALLO = 8'h17;
	localparam logic [7:0] IDX_DIAG_SELECT_ONE = 8'h18;
	localparam logic [7:0] IDX_DIAG_SELECT_TWO = 8'h19;
	// ----------------------------------------
	// fields
	// ----------------------------------------
	localparam logic [15:0] DEVCFG1_MASK = 16'h00FF;
	localparam int DEVCFG1_SPARE_LSB = 8;
	localparam logic [15:0] DEVCFG1_SPARE = 16'h0F00;
	localparam logic [15:0] DEVCFG2_MASK = 16'h00FF;
	localparam logic [15:0] DEVCFG2_SPARE = 16'h1F00;
	// scan control: [2:0] scan_config_field, [3] adc_scale_diag_enable
	localparam int SCAN_CFG_LSB = 0;
	localparam int SCAN_DIAG_EN_BIT = 3;
	localparam logic [15:0] SCANCTL_MASK = 16'h000F;
	localparam logic [2:0] SCAN_ADC_A = 3'h0;
	localparam logic [2:0] SCAN_ADC_B = 3'h1;
	// safety diag status two
	localparam int FS_ALERT_BIT = 0;
	localparam int ZS_ALERT_BIT = 1;
	// general status one / two
	localparam int S1_PROTO_BIT = 0;
	localparam int S1_REJECT_BIT = 1;
	localparam int S2_PROTO_BIT = 0;
	localparam logic [11:0] ADC_FULL = 12'hFFF;
	localparam logic [11:0] ADC_ZERO = 12'h000;
	localparam int NCELL = 14;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage

// ===== sim/rmd_chk.sv
// checker for rmd_core bus answers and diag output timing
// bound to rmd_core; sees its ports only
`timescale 1ns/1ps
module rmd_chk
	import rmd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic proto_err,
	input wire logic scan_done,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	input wire logic diag_run,
	input wire logic [2:0] diag_adc_mode
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire [7:0] idx = paddr[9:2];
	wire rsv = idx > USER_LAST || (idx >= HOLE_LO && idx <= HOLE_HI) || idx == HOLE_ONE;
	wire ok = !proto_err && paddr[1:0] == 2'h0 && (!pwrite || pstrb[1:0] == 2'h3);
	wire fin = psel && penable && pready;
	a_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("no answer after wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_flag: assert property (fin && !ok |-> pslverr)
		else $error("faulty transfer not refused");
	a_clean_ok: assert property (fin && ok |-> !pslverr)
		else $error("clean transfer refused");
	a_resv_zero: assert property (fin && ok && !pwrite && rsv |-> prdata == ZERO32)
		else $error("reserved read not zero");
	a_upper_zero: assert property (fin && !pwrite |-> prdata[31:16] == ZERO16)
		else $error("upper read bits not zero");
	a_run_cause: assert property (diag_run |-> $past(scan_done))
		else $error("scale check without scan end");
	a_mode_follow: assert property (fin && ok && pwrite && idx == IDX_DEVCFG1
		|-> ##2 diag_adc_mode == $past(pwdata[2:0], 2))
		else $error("config field not taken");
	cover property (fin && ok && pwrite);
	cover property (fin && ok && rsv);
	cover property (diag_run);
endmodule // rmd_chk

bind rmd_core rmd_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pstrb, .proto_err, .scan_done, .pready, .pslverr, .prdata, .diag_run, .diag_adc_mode);

// ===== sim/rmd_host.sv
// host model: apb master standing in for the serial host
// driven by tb through xfer; one transfer at a time
`timescale 1ns/1ps
module rmd_host (
	input wire logic pclk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	output logic proto_err
);
	initial {psel, penable, pwrite, paddr, pwdata, pstrb, proto_err} = '0;
	// e[0] marks a failed word check, e[1] a bad strobe
	task automatic xfer(input logic w, input logic [7:0] i, input logic [15:0] v,
		input logic [1:0] e, output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, i, 2'h0};
		pwdata <= {16'h0000, v};
		pstrb <= e[1] ? 4'h1 : 4'hF;
		proto_err <= e[0];
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable, proto_err} <= 3'h0;
		pwdata <= ~pwdata;
		paddr <= ~paddr;
	endtask
endmodule // rmd_host

// ===== sim/tb.sv
// testbench of rmd_core: bus, reserved space, status and alerts
// host model drives apb; bench drives scan and open-wire events
`timescale 1ns/1ps
module tb
	import rmd_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic scan_done = 1'b0;
	logic diag_done = 1'b0;
	logic busy = 1'b0;
	logic [11:0] fs_code = 12'h000;
	logic [11:0] zs_code = 12'h000;
	logic [13:0] over_hi = 14'h0000;
	logic [13:0] under_lo = 14'h0000;
	logic psel, penable, pwrite, proto_err, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, d;
	logic [31:0] seed = 32'h7A541B78;
	logic [3:0] pstrb, sc;
	logic [15:0] c1;
	int err_count = 0;
	int n_compared = 0;
	int n;
	logic [7:0] rs [8] = '{8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h46, 8'h98, 8'h99, 8'hFF};
	always #2.5 pclk = ~pclk;
	rmd_host host (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .proto_err);
	rmd_core dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .proto_err, .scan_done, .adc_mode(3'h0), .fs_code, .zs_code, .diag_done,
		.cell_over_hi(over_hi), .cell_under_lo(under_lo), .busy, .pready, .pslverr, .prdata,
		.diag_run(), .diag_adc_mode());
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] alerts(logic [3:0] s, logic [11:0] f, logic [11:0] z);
		logic q;
		q = s[3] && (s[2:0] == SCAN_ADC_A || s[2:0] == SCAN_ADC_B);
		return {30'h0, q && z > ADC_ZERO, q && f < ADC_FULL};
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] i, input logic [15:0] v, input logic [1:0] e);
		host.xfer(1'b1, i, v, e, rd, er);
	endtask
	task rc(input logic [7:0] i, input logic [31:0] x);
		host.xfer(1'b0, i, 16'h0000, 2'h0, rd, er);
		chk(rd, x);
	endtask
	task ow(input logic [13:0] h, input logic [13:0] l, input logic [31:0] x);
		@(posedge pclk);
		diag_done <= 1'b1;
		over_hi <= h;
		under_lo <= l;
		@(posedge pclk);
		diag_done <= 1'b0;
		rc(IDX_BALALRT, x);
		rc(IDX_BALHI, {18'h00000, h});
		rc(IDX_BALLO, {18'h00000, l});
		wr(IDX_BALALRT, 16'h0001, 2'h0);
		wr(IDX_BALHI, 16'h3FFF, 2'h0);
		wr(IDX_BALLO, 16'h3FFF, 2'h0);
	endtask
	task wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		err_count++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			d = rnd();
			c1 = d[15:0] & (DEVCFG1_MASK | DEVCFG1_SPARE);
			wr(IDX_DEVCFG1, d[15:0], 2'h0);
			rc(IDX_DEVCFG1, {16'h0000, c1});
			wr(IDX_DEVCFG2, d[31:16], 2'h0);
			rc(IDX_DEVCFG2, {16'h0000, d[31:16] & (DEVCFG2_MASK | DEVCFG2_SPARE)});
		end
		for (int k = 1; k < 4; k++) begin
			wr(HOLE_LO, 16'hFFFF, k[1:0]);
			chk({31'h0, er}, 32'h1);
			wr(IDX_DEVCFG1, ~c1, k[1:0]);
			rc(IDX_DEVCFG1, {16'h0000, c1});
			rc(IDX_GENERAL_STATUS_ONE, 32'h1);
			rc(IDX_GENERAL_STATUS_TWO, 32'h1);
			wr(IDX_GENERAL_STATUS_ONE, 16'h0001, 2'h0);
			wr(IDX_GENERAL_STATUS_TWO, 16'h0001, 2'h0);
		end
		// writes to reserved space and to unused 0x98 must raise no error and read back zero
		foreach (rs[k]) begin
			d = rnd();
			wr(rs[k], d[15:0], 2'h0);
			chk({31'h0, er}, 32'h0);
			rc(rs[k], 32'h0);
		end
		rc(IDX_GENERAL_STATUS_ONE, 32'h0);
		wr(IDX_SCANCTL, 16'h0009, 2'h0);
		busy <= 1'b1;
		wr(IDX_SCANCTL, 16'h0002, 2'h0);
		rc(IDX_SCANCTL, 32'h9);
		busy <= 1'b0;
		rc(IDX_GENERAL_STATUS_ONE, 32'h2);
		wr(IDX_GENERAL_STATUS_ONE, 16'h0002, 2'h0);
		for (int k = 0; k < 24; k++) begin
			d = rnd();
			sc = k < 16 ? k[3:0] : d[27:24];
			wr(IDX_SCANCTL, {12'h000, sc}, 2'h0);
			@(posedge pclk);
			scan_done <= 1'b1;
			fs_code <= d[31] ? ADC_FULL : d[11:0];
			zs_code <= d[30] ? ADC_ZERO : d[23:12];
			@(posedge pclk);
			scan_done <= 1'b0;
			rc(IDX_SAFETY2, alerts(sc, fs_code, zs_code));
			wr(IDX_SAFETY2, 16'h0003, 2'h0);
		end
		for (int k = 0; k < 4; k++) begin
			d = rnd();
			n = d[3:0] % 13;
			ow(14'h0000, 14'h0003 << n, 32'h0);
			ow(14'h0001 << n, 14'h0000, 32'h1);
			ow(14'h0003 << n, 14'h0000, 32'h0);
		end
		wrap_up();
	end
endmodule // tb
